// File: sim/ssec_ext_master.sv
// external master model driving select line 0 and the serial clock
module ssec_ext_master (
	input  wire logic go,     // rising edge starts one frame
	output logic      sclk,   // serial clock, still outside frames
	output logic      ssel_b  // select line 0, active low
);
	timeunit 1ns;
	timeprecision 1ns;
	// four clocks of 400 ns with select held around them, one process drives both pins
	initial begin
		sclk = 1'b0;
		ssel_b = 1'b1;
		forever begin
			@(posedge go);
			ssel_b = 1'b0;
			#400;
			repeat (4) begin
				sclk = 1'b1;
				#200;
				sclk = 1'b0;
				#200;
			end
			#400;
			ssel_b = 1'b1;
		end
	end
endmodule : ssec_ext_master

// File: sim/ssec_select_error_ctrl_assertions.sv
// concurrent checks on the ports of the select, error and request block
module ssec_checker
	import ssec_pkg::*;
(
	input wire logic       CLK,               // clock
	input wire logic       RST_B,             // reset
	input wire logic [1:0] MODE_SEL,          // mode
	input wire logic [3:0] SEL_POL,           // polarity
	input wire logic       CYCLE_TICK,        // tick
	input wire logic       RX_DONE,           // frame in
	input wire logic       RX_FULL,           // rx full
	input wire logic       TX_EMPTY,          // tx empty
	input wire logic       PARITY_ERR,        // parity set
	input wire logic       CLR_PARITY,        // parity clear
	input wire logic       ERR_IE,            // enable
	input wire logic       RX_IE,             // enable
	input wire logic       TX_IE,             // enable
	input wire logic       SELECT_LINE_0_OUT, // drive
	input wire logic       SELECT_LINE_1_OUT, // drive
	input wire logic       SELECT_LINE_2_OUT, // drive
	input wire logic       SELECT_LINE_3_OUT, // drive
	input wire logic       SELECT_LINE_0_OE,  // enable
	input wire logic       SELECT_LINE_1_OE,  // enable
	input wire logic       SELECT_LINE_2_OE,  // enable
	input wire logic       SELECT_LINE_3_OE,  // enable
	input wire logic       XFER_RUN,          // clock may run
	input wire logic       MODE_FAULT_FLAG,   // flag
	input wire logic       UNDERRUN_FLAG,     // flag
	input wire logic       OVERRUN_FLAG,      // flag
	input wire logic       PARITY_FLAG,       // flag
	input wire logic       IDLE_FLAG,         // flag
	input wire logic       ERR_IRQ,           // request
	input wire logic       RX_IRQ,            // request
	input wire logic       TX_IRQ             // request
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [3:0] outs = {SELECT_LINE_3_OUT, SELECT_LINE_2_OUT,
		SELECT_LINE_1_OUT, SELECT_LINE_0_OUT};
	wire logic [3:0] oes = {SELECT_LINE_3_OE, SELECT_LINE_2_OE, SELECT_LINE_1_OE, SELECT_LINE_0_OE};
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	parity_set_a: assert property (PARITY_ERR |=> PARITY_FLAG)
		else $error("parity not flagged");
	ovr_set_a: assert property (RX_DONE && RX_FULL |=> OVERRUN_FLAG)
		else $error("overrun lost");
	err_merge_a: assert property ((PARITY_FLAG || OVERRUN_FLAG || MODE_FAULT_FLAG)
		&& $past(ERR_IE) |-> ERR_IRQ) else $error("error request missing");
	rx_req_a: assert property (RX_IE && RX_FULL |=> RX_IRQ)
		else $error("rx request missing");
	tx_req_a: assert property (TX_IE && TX_EMPTY |=> TX_IRQ)
		else $error("tx request missing");
	rx_drop_a: assert property (!RX_FULL |=> !RX_IRQ)
		else $error("rx request stale");
	flag_hold_a: assert property (PARITY_FLAG && !CLR_PARITY |=> PARITY_FLAG)
		else $error("flag lost");
	mode_fault_flag_merge_a: assert property (UNDERRUN_FLAG |-> MODE_FAULT_FLAG)
		else $error("underrun hidden");
	single_dir_a: assert property (MODE_SEL == SSEC_MODE_SINGLE |=> oes == SSEC_OE_ALL)
		else $error("dir");
	multi_in_a: assert property (MODE_SEL == SSEC_MODE_MULTI |=> !SELECT_LINE_0_OE)
		else $error("line 0 driven");
	slave_dir_a: assert property (MODE_SEL == SSEC_MODE_SLAVE |=> oes == SSEC_OE_NONE)
		else $error("dir");
	run_tick_a: assert property ($rose(XFER_RUN) |-> $past(CYCLE_TICK))
		else $error("clock early");
	idle_sel_a: assert property (IDLE_FLAG && MODE_SEL == SSEC_MODE_SINGLE
		&& $stable(MODE_SEL) && $stable(SEL_POL) |-> outs == ~SEL_POL)
		else $error("select active in idle");
	cover property ($rose(XFER_RUN));
	cover property ($rose(ERR_IRQ));
	cover property ($rose(UNDERRUN_FLAG));
endmodule : ssec_checker

bind ssec_select_error_ctrl ssec_checker i_chk (.*);

// File: sim/ssec_select_error_ctrl_tb.sv
// self-checking bench for the select, error and request block
module ssec_select_error_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ssec_pkg::*;
	logic       CLK = 0, RST_B = 0, go = 0;
	logic [1:0] MODE_SEL = SSEC_MODE_SINGLE, TARGET = 2'h0;
	logic [3:0] SEL_POL = 4'h5;
	logic [3:1] SEL_OUT_EN = 3'h0;
	logic [2:0] CLK_DELAY = 3'h0, NEG_DELAY = 3'h0, NEXT_DELAY = 3'h0;
	logic       CYCLE_TICK = 0, START = 0, XFER_DONE = 0, RX_FULL = 0, RX_DONE = 0;
	logic       TX_EMPTY = 0, PARITY_ERR = 0, CLR_MODE_FAULT = 0, CLR_OVERRUN = 0;
	logic       CLR_PARITY = 0, ERR_IE = 1, RX_IE = 1, TX_IE = 1, IDLE_IE = 1;
	logic       SERIAL_CLOCK_LINE, SELECT_LINE_0_IN, XFER_RUN, IDLE_FLAG;
	logic       SELECT_LINE_0_OUT, SELECT_LINE_1_OUT, SELECT_LINE_2_OUT, SELECT_LINE_3_OUT;
	logic       SELECT_LINE_0_OE, SELECT_LINE_1_OE, SELECT_LINE_2_OE, SELECT_LINE_3_OE;
	logic       MODE_FAULT_FLAG, UNDERRUN_FLAG, OVERRUN_FLAG, PARITY_FLAG;
	logic       ERR_IRQ, RX_IRQ, TX_IRQ, IDLE_IRQ;
	wire logic [3:0] so = {SELECT_LINE_3_OUT, SELECT_LINE_2_OUT,
		SELECT_LINE_1_OUT, SELECT_LINE_0_OUT};
	wire logic [3:0] oe = {SELECT_LINE_3_OE, SELECT_LINE_2_OE, SELECT_LINE_1_OE, SELECT_LINE_0_OE};
	int fails = 0, checks = 0, cyc = 0;

	ssec_select_error_ctrl i_dut (.*);
	ssec_ext_master i_ext (.go(go), .sclk(SERIAL_CLOCK_LINE), .ssel_b(SELECT_LINE_0_IN));

	initial forever #25 CLK = ~CLK;

	task automatic test_done();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	always @(posedge CLK) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			test_done();
		end
	end

	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one-cycle pulse; outputs it causes are settled on return
	task automatic pulse(ref logic s);
		@(negedge CLK);
		s = 1'b1;
		@(negedge CLK);
		s = 1'b0;
	endtask : pulse

	task automatic xfer(input logic [1:0] t, input logic [2:0] d);
		logic [3:0] idle_v;
		idle_v = ~SEL_POL;
		CLK_DELAY = d;
		NEG_DELAY = d;
		NEXT_DELAY = d;
		TARGET = t;
		pulse(START);
		chk(so, idle_v ^ (4'h1 << t));
		for (int i = 0; i <= d; i++) begin
			chk(XFER_RUN, 4'h0);
			pulse(CYCLE_TICK);
		end
		chk(XFER_RUN, 4'h1);
		pulse(XFER_DONE);
		for (int i = 0; i <= d; i++) begin
			chk(so, idle_v ^ (4'h1 << t));
			pulse(CYCLE_TICK);
		end
		chk(so, idle_v);
		for (int i = 0; i <= d; i++) begin
			chk({so == idle_v, IDLE_FLAG}, 4'h2);
			pulse(CYCLE_TICK);
		end
		chk({IDLE_FLAG, IDLE_IRQ}, 4'h3);
	endtask : xfer

	initial begin
		repeat (16) @(negedge CLK);
		RST_B = 1'b1;
		@(negedge CLK);
		chk(oe, 4'hF);
		chk(so, 4'hA);
		for (int t = 0; t < 4; t++) begin
			SEL_POL = ~SEL_POL;
			xfer(2'(t), 3'(7 * t));
		end
		pulse(PARITY_ERR);
		chk({PARITY_FLAG, ERR_IRQ}, 4'h3);
		repeat (3) @(negedge CLK);
		chk({PARITY_FLAG, ERR_IRQ}, 4'h3);
		pulse(CLR_PARITY);
		chk({PARITY_FLAG, ERR_IRQ}, 4'h0);
		RX_FULL = 1'b1;
		pulse(RX_DONE);
		chk({OVERRUN_FLAG, ERR_IRQ, RX_IRQ}, 4'h7);
		RX_FULL = 1'b0;
		pulse(CLR_OVERRUN);
		chk({OVERRUN_FLAG, ERR_IRQ, RX_IRQ}, 4'h0);
		TX_EMPTY = 1'b1;
		repeat (2) @(negedge CLK);
		chk(TX_IRQ, 4'h1);
		TX_EMPTY = 1'b0;
		repeat (2) @(negedge CLK);
		chk(TX_IRQ, 4'h0);
		TX_EMPTY = 1'b1;
		TX_IE = 1'b0;
		repeat (2) @(negedge CLK);
		chk(TX_IRQ, 4'h0);
		TX_IE = 1'b1;
		// the partner's select idles high, so line 0 is made active low
		MODE_SEL = SSEC_MODE_MULTI;
		SEL_POL = 4'hA;
		SEL_OUT_EN = 3'h5;
		repeat (2) @(negedge CLK);
		chk(oe, 4'hA);
		repeat (4) @(negedge CLK);
		chk(MODE_FAULT_FLAG, 4'h0);
		go = 1'b1;
		repeat (8) @(negedge CLK);
		chk({MODE_FAULT_FLAG, ERR_IRQ}, 4'h3);
		repeat (60) @(negedge CLK);
		go = 1'b0;
		pulse(CLR_MODE_FAULT);
		chk({MODE_FAULT_FLAG, ERR_IRQ}, 4'h0);
		MODE_SEL = SSEC_MODE_SLAVE;
		TX_EMPTY = 1'b1;
		repeat (2) @(negedge CLK);
		chk(oe, 4'h0);
		pulse(START);
		chk({XFER_RUN, IDLE_FLAG}, 4'h1);
		go = 1'b1;
		repeat (20) @(negedge CLK);
		chk({UNDERRUN_FLAG, MODE_FAULT_FLAG, IDLE_FLAG}, 4'h6);
		repeat (40) @(negedge CLK);
		chk(IDLE_FLAG, 4'h1);
		pulse(CLR_MODE_FAULT);
		chk({UNDERRUN_FLAG, MODE_FAULT_FLAG, ERR_IRQ}, 4'h0);
		test_done();
	end
endmodule : ssec_select_error_ctrl_tb

// File: src/ssec_pkg.sv
// shared constants and types for the select, error and interrupt-source block
package ssec_pkg;

	localparam int         SSEC_DLY_W       = 3;
	localparam int         SSEC_LINES       = 4;
	localparam logic [1:0] SSEC_MODE_SINGLE = 2'h0;
	localparam logic [1:0] SSEC_MODE_MULTI  = 2'h1;
	localparam logic [1:0] SSEC_MODE_SLAVE  = 2'h2;
	localparam logic [SSEC_DLY_W-1:0] SSEC_CNT_ZERO = 3'h0;
	localparam logic [SSEC_LINES-1:0] SSEC_OE_ALL   = 4'hF;
	localparam logic [SSEC_LINES-1:0] SSEC_OE_NONE  = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CLK_DLY,
		ST_XFER,
		ST_NEG_DLY,
		ST_NEXT_DLY
	} ssec_state_e;

	typedef struct packed {
		ssec_state_e            st;
		logic [SSEC_DLY_W-1:0]  cnt;
		logic [1:0]             target;
		logic                   frame_on;
		logic                   mode_fault_flag;
		logic                   udr;
		logic                   ovr;
		logic                   par;
		logic                   fault;
		logic [SSEC_LINES-1:0]  sel_out;
		logic [SSEC_LINES-1:0]  sel_oe;
		logic                   run;
		logic                   idle;
		logic                   irq_err;
		logic                   irq_rx;
		logic                   irq_tx;
		logic                   irq_idle;
	} ssec_main_s;

	localparam ssec_main_s SSEC_MAIN_RST = '0;

	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
		logic rise;
		logic fall;
	} ssec_sync_s;

	localparam ssec_sync_s SSEC_SYNC_RST = '0;

endpackage : ssec_pkg

// File: src/ssec_select_error_ctrl.sv
// select sequencing, error detection and interrupt requests of a four-wire serial channel
// Behaviour
// [R1] detect mode fault, overrun, parity, underrun errors
// [R2] all four errors share one error request
// [R3] receive request while receive buffer full
// [R4] transmit request while transmit buffer empty
// [R5] idle request when no transfer in progress
// [R6] four select lines, direction set by mode
// [R7] single master drives all four selects
// [R8] multi master: line 0 input, others optional
// [R9] slave: line 0 input, others unused
// [R10] select to clock delay 1..8 cycles
// [R11] clock stop to negation delay 1..8
// [R12] next-access wait 1..8 cycles before select
// [R13] per-line selectable select polarity
// [R14] mode fault flag also reports underrun
// [R15] selects inactive whenever no transfer runs
// [R16] requests held until cause serviced or cleared
module ssec_select_error_ctrl
	import ssec_pkg::*;
#(
	parameter int DLY_W = SSEC_DLY_W
)
(
	input  wire logic             CLK,                // 20 MHz block clock
	input  wire logic             RST_B,              // async reset, active low
	input  wire logic [1:0]       MODE_SEL,           // single, multi master or slave
	input  wire logic [3:0]       SEL_POL,            // 1 makes a select active high
	input  wire logic [3:1]       SEL_OUT_EN,         // multi master: lines 1..3 used
	input  wire logic [DLY_W-1:0] CLK_DELAY,          // select to clock, value+1 cycles
	input  wire logic [DLY_W-1:0] NEG_DELAY,          // clock stop to negation
	input  wire logic [DLY_W-1:0] NEXT_DELAY,         // wait before next select
	input  wire logic             CYCLE_TICK,         // one pulse per serial-clock cycle
	input  wire logic             START,              // pulse: begin an access
	input  wire logic [1:0]       TARGET,             // select line for the access
	input  wire logic             XFER_DONE,          // pulse: shift path finished
	input  wire logic             RX_FULL,            // receive buffer holds unread data
	input  wire logic             RX_DONE,            // pulse: frame received
	input  wire logic             TX_EMPTY,           // transmit buffer empty
	input  wire logic             PARITY_ERR,         // pulse: parity mismatch
	input  wire logic             CLR_MODE_FAULT,     // pulse: clear mode fault and underrun
	input  wire logic             CLR_OVERRUN,        // pulse: clear overrun
	input  wire logic             CLR_PARITY,         // pulse: clear parity error
	input  wire logic             ERR_IE,             // error request enable
	input  wire logic             RX_IE,              // receive request enable
	input  wire logic             TX_IE,              // transmit request enable
	input  wire logic             IDLE_IE,            // idle request enable
	input  wire logic             SERIAL_CLOCK_LINE,  // serial clock pin as seen by slave
	input  wire logic             SELECT_LINE_0_IN,   // select line 0 pin level
	output logic                  SELECT_LINE_0_OUT,  // select line 0 drive level
	output logic                  SELECT_LINE_0_OE,   // select line 0 drive enable
	output logic                  SELECT_LINE_1_OUT,  // select line 1 drive level
	output logic                  SELECT_LINE_1_OE,   // select line 1 drive enable
	output logic                  SELECT_LINE_2_OUT,  // select line 2 drive level
	output logic                  SELECT_LINE_2_OE,   // select line 2 drive enable
	output logic                  SELECT_LINE_3_OUT,  // select line 3 drive level
	output logic                  SELECT_LINE_3_OE,   // select line 3 drive enable
	output logic                  XFER_RUN,           // serial clock may run
	output logic                  MODE_FAULT_FLAG,    // mode fault or underrun
	output logic                  UNDERRUN_FLAG,      // underrun alone
	output logic                  OVERRUN_FLAG,       // receive overrun
	output logic                  PARITY_FLAG,        // parity error
	output logic                  IDLE_FLAG,          // interface idle
	output logic                  ERR_IRQ,            // shared error request
	output logic                  RX_IRQ,             // receive buffer full request
	output logic                  TX_IRQ,             // transmit buffer empty request
	output logic                  IDLE_IRQ            // idle request
);

	ssec_main_s state_reg;
	ssec_main_s state_next;

	logic sck_rise;
	logic sel0_lvl;

	ssec_sync_edge u_sck_sync (
		.CLK   (CLK),
		.RST_B (RST_B),
		.PIN   (SERIAL_CLOCK_LINE),
		.LEVEL (),
		.RISE  (sck_rise),
		.FALL  ()
	);

	ssec_sync_edge u_sel0_sync (
		.CLK   (CLK),
		.RST_B (RST_B),
		.PIN   (SELECT_LINE_0_IN),
		.LEVEL (sel0_lvl),
		.RISE  (),
		.FALL  ()
	);

	// returns {done, next count}; done on the tick that ends the last cycle
	function automatic logic [DLY_W:0] count_step(
		input logic             tick,
		input logic [DLY_W-1:0] cnt
	);
		logic [DLY_W:0] res;
		res = {1'b0, cnt};
		if (tick) begin
			if (cnt == SSEC_CNT_ZERO) begin
				res = {1'b1, cnt};
			end else begin
				res = {1'b0, DLY_W'(cnt - 1'b1)};
			end
		end
		return res;
	endfunction : count_step

	// sticky flag: a set in the clearing cycle wins
	function automatic logic flag_next(
		input logic flag,
		input logic set,
		input logic clr
	);
		return set | (flag & ~clr);
	endfunction : flag_next

	always_comb begin
		logic           master;
		logic           sel0_act;
		logic           sel_on;
		logic           mode_fault_flag_set;
		logic           udr_set;
		logic           ovr_set;
		logic [DLY_W:0] step;
		master     = 1'b0;
		sel0_act   = 1'b0;
		sel_on     = 1'b0;
		mode_fault_flag_set   = 1'b0;
		udr_set    = 1'b0;
		ovr_set    = 1'b0;
		step       = count_step(CYCLE_TICK, state_reg.cnt);
		state_next = state_reg;

		master   = (MODE_SEL == SSEC_MODE_SINGLE) || (MODE_SEL == SSEC_MODE_MULTI);
		sel0_act = (sel0_lvl == SEL_POL[0]);                                   // [R13]

		// another master pulling line 0 active is a mode fault
		mode_fault_flag_set = (MODE_SEL == SSEC_MODE_MULTI) && sel0_act;                  // [R1] [R8]
		// first slave clock edge of a frame with nothing to send
		udr_set  = (MODE_SEL == SSEC_MODE_SLAVE) && sel0_act && sck_rise
			&& !state_reg.frame_on && TX_EMPTY;                                  // [R1] [R9]
		ovr_set  = RX_DONE && RX_FULL;                                         // [R1]

		if ((MODE_SEL == SSEC_MODE_SLAVE) && sel0_act) begin                   // [R9]
			if (sck_rise) begin
				state_next.frame_on = 1'b1;
			end
		end else begin
			state_next.frame_on = 1'b0;
		end

		state_next.mode_fault_flag = flag_next(state_reg.mode_fault_flag, mode_fault_flag_set, CLR_MODE_FAULT); // [R1]
		state_next.udr  = flag_next(state_reg.udr, udr_set, CLR_MODE_FAULT);   // [R1]
		state_next.ovr  = flag_next(state_reg.ovr, ovr_set, CLR_OVERRUN);      // [R1]
		state_next.par  = flag_next(state_reg.par, PARITY_ERR, CLR_PARITY);    // [R1]
		state_next.fault = state_next.mode_fault_flag | state_next.udr;                   // [R14]

		unique case (state_reg.st)
			ST_IDLE: begin
				if (START && master && !state_reg.mode_fault_flag) begin
					state_next.st     = ST_CLK_DLY;
					state_next.cnt    = CLK_DELAY;
					state_next.target = TARGET;
				end
			end
			ST_CLK_DLY: begin
				state_next.cnt = step[DLY_W-1:0];
				if (step[DLY_W]) begin                                             // [R10]
					state_next.st = ST_XFER;
				end
			end
			ST_XFER: begin
				if (XFER_DONE) begin
					state_next.st  = ST_NEG_DLY;
					state_next.cnt = NEG_DELAY;
				end
			end
			ST_NEG_DLY: begin
				state_next.cnt = step[DLY_W-1:0];
				if (step[DLY_W]) begin                                             // [R11]
					state_next.st  = ST_NEXT_DLY;
					state_next.cnt = NEXT_DELAY;
				end
			end
			ST_NEXT_DLY: begin
				state_next.cnt = step[DLY_W-1:0];
				if (step[DLY_W]) begin                                             // [R12]
					state_next.st = ST_IDLE;
				end
			end
			default: begin
				state_next.st = ST_IDLE;
			end
		endcase

		// a mode fault or a change to slave ends the access at once
		if (mode_fault_flag_set || !master) begin
			state_next.st = ST_IDLE;
		end

		sel_on = (state_next.st == ST_CLK_DLY) || (state_next.st == ST_XFER)
			|| (state_next.st == ST_NEG_DLY);                                    // [R15]
		for (int i = 0; i < SSEC_LINES; i++) begin
			if (sel_on && (state_next.target == 2'(i))) begin
				state_next.sel_out[i] = SEL_POL[i];                                // [R13]
			end else begin
				state_next.sel_out[i] = ~SEL_POL[i];                               // [R15]
			end
		end

		unique case (MODE_SEL)
			SSEC_MODE_SINGLE: state_next.sel_oe = SSEC_OE_ALL;                   // [R6] [R7]
			SSEC_MODE_MULTI:  state_next.sel_oe = {SEL_OUT_EN, 1'b0};            // [R6] [R8]
			default:          state_next.sel_oe = SSEC_OE_NONE;                  // [R6] [R9]
		endcase

		state_next.run  = (state_next.st == ST_XFER);
		state_next.idle = master ? (state_next.st == ST_IDLE) : !sel0_act;

		// requests are levels that fall when the cause goes away or the enable is cleared
		state_next.irq_err  = ERR_IE & (state_next.mode_fault_flag | state_next.udr
			| state_next.ovr | state_next.par);                                  // [R2] [R16]
		state_next.irq_rx   = RX_IE & RX_FULL;                                 // [R3] [R16]
		state_next.irq_tx   = TX_IE & TX_EMPTY;                                // [R4] [R16]
		state_next.irq_idle = IDLE_IE & state_next.idle;                       // [R5] [R16]
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= SSEC_MAIN_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign SELECT_LINE_0_OUT = state_reg.sel_out[0];
	assign SELECT_LINE_0_OE  = state_reg.sel_oe[0];
	assign SELECT_LINE_1_OUT = state_reg.sel_out[1];
	assign SELECT_LINE_1_OE  = state_reg.sel_oe[1];
	assign SELECT_LINE_2_OUT = state_reg.sel_out[2];
	assign SELECT_LINE_2_OE  = state_reg.sel_oe[2];
	assign SELECT_LINE_3_OUT = state_reg.sel_out[3];
	assign SELECT_LINE_3_OE  = state_reg.sel_oe[3];
	assign XFER_RUN          = state_reg.run;
	assign MODE_FAULT_FLAG   = state_reg.fault;
	assign UNDERRUN_FLAG     = state_reg.udr;
	assign OVERRUN_FLAG      = state_reg.ovr;
	assign PARITY_FLAG       = state_reg.par;
	assign IDLE_FLAG         = state_reg.idle;
	assign ERR_IRQ           = state_reg.irq_err;
	assign RX_IRQ            = state_reg.irq_rx;
	assign TX_IRQ            = state_reg.irq_tx;
	assign IDLE_IRQ          = state_reg.irq_idle;

endmodule : ssec_select_error_ctrl

// File: src/ssec_sync_edge.sv
// two-stage synchroniser with edge detection for one pin
module ssec_sync_edge
	import ssec_pkg::*;
(
	input  wire logic CLK,      // block clock
	input  wire logic RST_B,    // async reset, active low
	input  wire logic PIN,      // asynchronous pin level
	output logic      LEVEL,    // synchronised level
	output logic      RISE,     // one-cycle pulse on rising edge
	output logic      FALL      // one-cycle pulse on falling edge
);

	ssec_sync_s state_reg;
	ssec_sync_s state_next;

	always_comb begin
		state_next      = state_reg;
		state_next.meta = PIN;
		state_next.sync = state_reg.meta;
		state_next.last = state_reg.sync;
		state_next.rise = state_reg.sync & ~state_reg.last;
		state_next.fall = ~state_reg.sync & state_reg.last;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= SSEC_SYNC_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign LEVEL = state_reg.last;
	assign RISE  = state_reg.rise;
	assign FALL  = state_reg.fall;

endmodule : ssec_sync_edge
